//--- core/sss_exec.sv
// Execution block for low-power entry, subtract and nibble exchange
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Overview of operation
// - Low-power opcode halts oscillator in one cycle
// - Low-power pulses watchdog clear
// - Low-power sets time-out flag
// - Low-power clears power-down flag, keeps wakeup flag
// - Subtract computes file minus work register
// - Destination bit picks work or file
// - Subtract updates carry, digit carry, zero
// - Nibble exchange swaps upper and lower nibbles
// - Exchange result to destination, flags untouched
// ---------------------------------------------------------------
module sss_exec #(
  parameter int DATA_W = 8,
  parameter int INSN_W = 12,
  parameter int ADDR_W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic insn_valid,
  input wire logic [INSN_W-1:0] insn,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic wake_event,
  input wire logic pin_change_wakeup_flag,
  output logic [ADDR_W-1:0] file_addr,
  output logic file_we,
  output logic [DATA_W-1:0] file_wdata,
  output logic [DATA_W-1:0] work_reg,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic pin_change_wakeup_flag_out,
  output logic watchdog_clear,
  output logic osc_halt
);
  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  sss_pkg::sss_op_e op;
  logic dest_file;
  logic [DATA_W-1:0] diff;
  logic [DATA_W-1:0] swapped;
  logic alu_c;
  logic alu_dc;
  // Classify the word; the address field is used straight off the bus
  always_comb begin
    op = sss_pkg::SSS_OP_NONE;
    if (insn_valid && !osc_halt) begin
      if (insn == sss_pkg::OP_LOW_POWER) begin
        op = sss_pkg::SSS_OP_LOWP;
      end else if (insn[sss_pkg::OPC_HI:sss_pkg::OPC_LO] == sss_pkg::OP_SUB_WORK) begin
        op = sss_pkg::SSS_OP_SUB;
      end else if (insn[sss_pkg::OPC_HI:sss_pkg::OPC_LO] == sss_pkg::OP_NIB_EXCH) begin
        op = sss_pkg::SSS_OP_SWAP;
      end
    end
    dest_file = insn[sss_pkg::DEST_BIT];
  end

  sss_alu #(
    .DATA_W(DATA_W)
  ) u_alu (
    .file_val(file_rdata),
    .work_val(work_reg),
    .diff(diff),
    .carry(alu_c),
    .digit_carry(alu_dc),
    .swapped(swapped)
  );

  // ---------------------------------------------------------------
  // Architectural state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] work_nxt;
  logic c_nxt;
  logic dc_nxt;
  logic z_nxt;
  logic to_nxt;
  logic pd_nxt;
  logic halt_nxt;
  logic wdc_nxt;
  logic fwe_nxt;
  logic [DATA_W-1:0] fwd_nxt;
  logic [ADDR_W-1:0] fad_nxt;
  logic [DATA_W-1:0] result;

  // Next values; the write port is registered so the file sees it one cycle later
  always_comb begin
    work_nxt = work_reg;
    c_nxt = carry_flag;
    dc_nxt = digit_carry_flag;
    z_nxt = zero_flag;
    to_nxt = timeout_flag;
    pd_nxt = powerdown_flag;
    halt_nxt = osc_halt;
    wdc_nxt = 1'b0;
    fwe_nxt = 1'b0;
    fwd_nxt = file_wdata;
    fad_nxt = file_addr;
    result = (op == sss_pkg::SSS_OP_SUB) ? diff : swapped;
    // Wake only releases the halt; status bits stay for software to read
    if (osc_halt && wake_event) begin
      halt_nxt = 1'b0;
    end
    case (op)
      sss_pkg::SSS_OP_LOWP: begin
        halt_nxt = 1'b1;
        wdc_nxt = 1'b1;
        to_nxt = 1'b1;
        pd_nxt = 1'b0;
      end
      sss_pkg::SSS_OP_SUB, sss_pkg::SSS_OP_SWAP: begin
        if (dest_file) begin
          fwe_nxt = 1'b1;
          fwd_nxt = result;
          fad_nxt = insn[ADDR_W-1:0];
        end else begin
          work_nxt = result;
        end
        if (op == sss_pkg::SSS_OP_SUB) begin
          c_nxt = alu_c;
          dc_nxt = alu_dc;
          z_nxt = (diff == sss_pkg::DATA_ZERO);
        end
      end
      default: begin
      end
    endcase
  end

  // Registers only; ce low freezes everything but reset
  always_ff @(posedge clk) begin
    if (rst) begin
      work_reg <= sss_pkg::DATA_ZERO;
      carry_flag <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
      osc_halt <= 1'b0;
      watchdog_clear <= 1'b0;
      file_we <= 1'b0;
      file_wdata <= sss_pkg::DATA_ZERO;
      file_addr <= '0;
      pin_change_wakeup_flag_out <= 1'b0;
    end else if (ce) begin
      work_reg <= work_nxt;
      carry_flag <= c_nxt;
      digit_carry_flag <= dc_nxt;
      zero_flag <= z_nxt;
      timeout_flag <= to_nxt;
      powerdown_flag <= pd_nxt;
      osc_halt <= halt_nxt;
      watchdog_clear <= wdc_nxt;
      file_we <= fwe_nxt;
      file_wdata <= fwd_nxt;
      file_addr <= fad_nxt;
      pin_change_wakeup_flag_out <= pin_change_wakeup_flag;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_lowp_halt: assert property (@(posedge clk) disable iff (rst)
    (ce && op == sss_pkg::SSS_OP_LOWP) |=> osc_halt && watchdog_clear)
    else $error("low-power did not halt and clear watchdog");
  chk_lowp_status: assert property (@(posedge clk) disable iff (rst)
    (ce && op == sss_pkg::SSS_OP_LOWP) |=> timeout_flag && !powerdown_flag)
    else $error("low-power status bits wrong");
  chk_wdc_cause: assert property (@(posedge clk) disable iff (rst)
    watchdog_clear |-> ($past(ce) && $past(op) == sss_pkg::SSS_OP_LOWP) ||
      (!$past(ce) && $past(watchdog_clear)))
    else $error("watchdog clear without low-power");
  chk_sub_work: assert property (@(posedge clk) disable iff (rst)
    (ce && op == sss_pkg::SSS_OP_SUB && !dest_file) |=> work_reg == $past(file_rdata) - $past(work_reg))
    else $error("subtract result wrong in work");
  chk_sub_carry: assert property (@(posedge clk) disable iff (rst)
    (ce && op == sss_pkg::SSS_OP_SUB) |=> carry_flag == ($past(file_rdata) >= $past(work_reg)))
    else $error("subtract carry wrong");
  chk_sub_zero: assert property (@(posedge clk) disable iff (rst)
    (ce && op == sss_pkg::SSS_OP_SUB) |=> zero_flag == ($past(file_rdata) == $past(work_reg)))
    else $error("subtract zero wrong");
  chk_swap_file: assert property (@(posedge clk) disable iff (rst)
    (ce && op == sss_pkg::SSS_OP_SWAP && dest_file) |=>
      file_we && file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("nibble exchange to file wrong");
  chk_swap_flags: assert property (@(posedge clk) disable iff (rst)
    (ce && op == sss_pkg::SSS_OP_SWAP) |=> $stable(carry_flag) && $stable(zero_flag) && $stable(digit_carry_flag))
    else $error("nibble exchange altered flags");
  chk_dest_addr: assert property (@(posedge clk) disable iff (rst)
    (ce && op == sss_pkg::SSS_OP_SUB && dest_file) |=> file_we && file_addr == $past(insn[ADDR_W-1:0]))
    else $error("file write address wrong");

  // Data path results, checked against the raw operands one cycle back
  localparam int NIB = sss_pkg::NIB_W;
  chk_sub_file: assert property (@(posedge clk) disable iff (rst)
    (ce && op == sss_pkg::SSS_OP_SUB && dest_file) |=>
      file_we && file_wdata == $past(file_rdata) - $past(work_reg))
    else $error("subtract result wrong in file");
  chk_sub_digit: assert property (@(posedge clk) disable iff (rst)
    (ce && op == sss_pkg::SSS_OP_SUB) |=>
      digit_carry_flag == ($past(file_rdata[NIB-1:0]) >= $past(work_reg[NIB-1:0])))
    else $error("subtract digit carry wrong");
  chk_swap_work: assert property (@(posedge clk) disable iff (rst)
    (ce && op == sss_pkg::SSS_OP_SWAP && !dest_file) |=>
      !file_we && work_reg == {$past(file_rdata[NIB-1:0]), $past(file_rdata[DATA_W-1:NIB])})
    else $error("nibble exchange to work wrong");

  // While halted nothing may execute; only a wake or reset releases the halt
  chk_halt_hold: assert property (@(posedge clk) disable iff (rst)
    (ce && osc_halt && !wake_event) |=> osc_halt && !file_we && $stable(work_reg))
    else $error("instruction ran while halted");
  chk_halt_wake: assert property (@(posedge clk) disable iff (rst)
    (ce && osc_halt && wake_event) |=> !osc_halt)
    else $error("wake did not release halt");
  chk_wdc_pulse: assert property (@(posedge clk) disable iff (rst)
    (ce && watchdog_clear) |=> !watchdog_clear)
    else $error("watchdog clear longer than one cycle");
  chk_wake_keep: assert property (@(posedge clk) disable iff (rst)
    (ce && op == sss_pkg::SSS_OP_LOWP) |=> pin_change_wakeup_flag_out == $past(pin_change_wakeup_flag))
    else $error("low-power altered wakeup flag");
endmodule

//--- shared/sss_pkg.sv
// Package with opcode patterns, field positions and reset values for the execution block
package sss_pkg;
  // ---------------------------------------------------------------
  // Instruction word layout
  // ---------------------------------------------------------------
  localparam int INSN_W = 12;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int DEST_BIT = 5;
  localparam int OPC_HI = 11;
  localparam int OPC_LO = 6;
  localparam int NIB_W = 4;
  // ---------------------------------------------------------------
  // Opcode patterns
  // ---------------------------------------------------------------
  localparam logic [11:0] OP_LOW_POWER = 12'h003;
  localparam logic [5:0] OP_SUB_WORK = 6'h02;
  localparam logic [5:0] OP_NIB_EXCH = 6'h0E;
  // ---------------------------------------------------------------
  // Reset and forced values
  // ---------------------------------------------------------------
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam logic [7:0] PRESC_CLEAR = 8'h00;
  // Kind of instruction being executed
  typedef enum logic [1:0] {
    SSS_OP_NONE = 2'b00,
    SSS_OP_LOWP = 2'b01,
    SSS_OP_SUB = 2'b10,
    SSS_OP_SWAP = 2'b11
  } sss_op_e;
endpackage

//--- core/sss_alu.sv
// Arithmetic unit: subtract work from file and nibble exchange
`timescale 1ns/1ps
module sss_alu #(
  parameter int DATA_W = 8
) (
  input wire logic [DATA_W-1:0] file_val,
  input wire logic [DATA_W-1:0] work_val,
  output logic [DATA_W-1:0] diff,
  output logic carry,
  output logic digit_carry,
  output logic [DATA_W-1:0] swapped
);
  localparam int HALF = DATA_W / 2;
  logic [DATA_W:0] full_sum;
  logic [HALF:0] half_sum;
  // Two's complement: f + ~w + 1, carry out means no borrow
  always_comb begin
    full_sum = {1'b0, file_val} + {1'b0, ~work_val} + {{DATA_W{1'b0}}, 1'b1};
    half_sum = {1'b0, file_val[HALF-1:0]} + {1'b0, ~work_val[HALF-1:0]} + {{HALF{1'b0}}, 1'b1};
    diff = full_sum[DATA_W-1:0];
    carry = full_sum[DATA_W];
    digit_carry = half_sum[HALF];
    swapped = {file_val[HALF-1:0], file_val[DATA_W-1:HALF]};
  end
endmodule

//--- test/testbench.sv
// Self-checking bench for the low-power, subtract and nibble exchange block
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst = 1, ce = 1, insn_valid = 0, wake_event = 0, pcw = 0, pv = 0;
  logic [11:0] insn = 12'h000;
  logic [7:0] fm [32];
  logic [4:0] file_addr, a_e;
  logic [7:0] file_wdata, work_reg, w_e, d_e;
  logic file_we, carry_flag, digit_carry_flag, zero_flag, timeout_flag, powerdown_flag;
  logic pcw_out, watchdog_clear, osc_halt, c_e, dc_e, z_e, to_e, pd_e, h_e, we_e, wc_e, p_e;
  logic [31:0] r;
  int miscompares = 0, num_checks = 0, cyc = 0, seed = 32'h92106a62;

  initial forever #2.5 clk = ~clk;

  sss_exec dut_u (.clk(clk), .rst(rst), .ce(ce), .insn_valid(insn_valid), .insn(insn),
    .file_rdata(fm[insn[4:0]]), .wake_event(wake_event), .pin_change_wakeup_flag(pcw),
    .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata), .work_reg(work_reg),
    .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
    .pin_change_wakeup_flag_out(pcw_out), .watchdog_clear(watchdog_clear), .osc_halt(osc_halt));

  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string m);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, m, s, e);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Expected effect of one accepted instruction on the model state
  task automatic step(input logic [11:0] i, input logic [7:0] f);
    logic [7:0] res;
    res = {f[3:0], f[7:4]};
    if (i === sss_pkg::OP_LOW_POWER) begin
      {h_e, wc_e, to_e, pd_e} = 4'hE;
    end else if (i[11:6] == sss_pkg::OP_SUB_WORK || i[11:6] == sss_pkg::OP_NIB_EXCH) begin
      if (i[11:6] == sss_pkg::OP_SUB_WORK) begin
        res = f - w_e;
        {c_e, dc_e, z_e} = {f >= w_e, f[3:0] >= w_e[3:0], res == 8'h00};
      end
      if (i[5]) {we_e, a_e, d_e} = {1'h1, i[4:0], res};
      else w_e = res;
    end
  endtask

  // Reference model and file memory; ce low freezes the model state, but cyc and file memory writes carry on
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (file_we) fm[file_addr] <= file_wdata;
    if (rst) begin
      {w_e, c_e, dc_e, z_e, to_e, pd_e, h_e, we_e, wc_e} = 16'h0018; // Timeout and powerdown come up set
      {a_e, d_e, pv} = 14'h0000;
    end else if (ce) begin
      {we_e, wc_e, p_e, pv} = {2'h0, pcw, 1'h1};
      if (h_e) h_e = !wake_event;
      else if (insn_valid) step(insn, fm[insn[4:0]]);
    end
    if (cyc == 6000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // Outputs are settled by the falling edge
  always @(negedge clk) if (!rst) begin
    chk(work_reg, w_e, "work");
    chk(carry_flag, c_e, "carry");
    chk(digit_carry_flag, dc_e, "digit carry");
    chk(zero_flag, z_e, "zero");
    chk(osc_halt, h_e, "halt");
    chk(watchdog_clear, wc_e, "watchdog clear");
    chk(timeout_flag, to_e, "timeout");
    chk(powerdown_flag, pd_e, "powerdown");
    chk(file_we, we_e, "file write");
    if (we_e) chk(file_addr, a_e, "file addr");
    if (we_e) chk(file_wdata, d_e, "file data");
    if (pv) chk(pcw_out, p_e, "wakeup flag");
  end

  task automatic issue(input logic [11:0] i, input logic [7:0] v);
    @(posedge clk);
    fm[i[4:0]] <= v;
    insn <= i;
    insn_valid <= 1'h1;
  endtask

  initial begin
    for (int k = 0; k < 32; k++) fm[k] = $random(seed);
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    // Swap to work, subtracts to both destinations (the one to work borrows) and a file swap, then halt with requests refused
    issue(12'h381, 8'h20);
    issue(12'h0A3, 8'h03);
    issue(12'h084, 8'h01);
    issue(12'h0A5, 8'hFF);
    issue(12'h3A6, 8'hA5);
    issue(12'h003, 8'h00);
    repeat (4) issue(12'h087, 8'h10);
    @(posedge clk);
    wake_event <= 1'h1;
    @(posedge clk);
    wake_event <= 1'h0;
    $display("corner test done");
    // Random mix with a reset in mid-run
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk);
      r = $random(seed);
      insn <= (r[1:0] == 2'h0) ? sss_pkg::OP_LOW_POWER : {(r[3:2] == 2'h0) ? sss_pkg::OP_SUB_WORK :
        (r[3:2] == 2'h1) ? sss_pkg::OP_NIB_EXCH : r[13:8], r[19:14]};
      {wake_event, insn_valid, pcw, ce} <= {r[22:20] == 3'h0, r[23] | r[24], r[25], r[28:26] != 3'h0};
      rst <= (n >= 1500 && n < 1502);
    end
    @(posedge clk);
    $display("random test done");
    report_and_stop();
  end
endmodule
